// File: include/mtu_pkg.sv
// Package for the multi timer unit slice: widths, field codes, reset values.
// Assumes a single core clock; every control bit reaches the block as a port.
package mtu_pkg;
  localparam int CNT_W = 16;                         // Counter and compare width
  localparam int NUM_FRC = 3;                        // Free run counters selectable
  localparam int NUM_CMP = 2;                        // Compare channels in this slice
  localparam int NUM_CAP = 2;                        // Capture channels in this slice
  localparam int NUM_ADC = 3;                        // Converter units served
  localparam int DIV_W = 4;                          // Prescaler code width
  localparam int SEL_W = 2;                          // Counter select width
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;  // Counter restart value
  localparam logic [DIV_W-1:0] DIV_RST = 4'h0;       // Prescaler reset code
  // Capture edge selection codes
  localparam logic [1:0] EDGE_OFF = 2'h0;            // Edge detection disabled
  localparam logic [1:0] EDGE_RISE = 2'h1;           // Rising edge
  localparam logic [1:0] EDGE_FALL = 2'h2;           // Falling edge
  localparam logic [1:0] EDGE_BOTH = 2'h3;           // Both edges
  // Waveform generator modes
  typedef enum logic [0:0] {
    MTU_WF_THRU,                                     // Compare output passed through
    MTU_WF_PULSE_GATED                               // Pulse gated mode
  } mtu_wfmode_e;
endpackage

// File: verilog/mtu_prescale.sv
// Prescaler: divides the core clock by 2**code into a one-cycle enable.
// Assumes a synchronous code input; a code change restarts the phase loosely.
`timescale 1ns/1ns
module mtu_prescale (
  input wire logic core_clk_i,                      // Core clock
  input wire logic resetn_i,                        // Async reset, active low
  input wire logic run_i,                           // Divider allowed to run
  input wire logic [mtu_pkg::DIV_W-1:0] code_i,     // Divide by 2**code
  output logic tick_o                               // One-cycle count enable
);
  import mtu_pkg::*;

  logic [15:0] div_r; // Divide chain, advances only while running

  ////////////////////////////////////////////////////////////////////////
  // Divide chain runs only while counting, so a stop freezes the phase
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r <= 16'h0000;
    end else if (run_i) begin
      div_r <= div_r + 16'h0001;
    end
  end

  // Tick when the low code bits are all ones: one pulse each 2**code cycles
  always_comb begin
    logic [15:0] mask;
    mask = (16'h0001 << code_i) - 16'h0001;
    tick_o = run_i && ((div_r & mask) == mask);
  end
endmodule

// File: verilog/mtu_capture.sv
// One capture channel: edge detect on its input, latch the counter, flag it.
// Assumes the input is already synchronous to the core clock.
`timescale 1ns/1ns
module mtu_capture (
  input wire logic core_clk_i,                      // Core clock
  input wire logic resetn_i,                        // Async reset, active low
  input wire logic [1:0] edge_sel_i,                // Edge selection code
  input wire logic cap_in_i,                        // Capture input
  input wire logic [mtu_pkg::CNT_W-1:0] cnt_i,      // Selected counter value
  input wire logic flag_wr_i,                       // Flag write strobe
  input wire logic flag_wdata_i,                    // Flag write value
  output logic [mtu_pkg::CNT_W-1:0] cap_value_o,    // Captured counter value
  output logic flag_o                               // Valid edge flag
);
  import mtu_pkg::*;

  logic prev_r; // Previous input level
  logic hit;    // Selected edge seen

  ////////////////////////////////////////////////////////////////////////
  // Input history for edge detection
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= cap_in_i;
    end
  end

  // Edge decode against the selection code
  always_comb begin
    case (edge_sel_i)
      EDGE_RISE: hit = cap_in_i && !prev_r;
      EDGE_FALL: hit = !cap_in_i && prev_r;
      EDGE_BOTH: hit = cap_in_i ^ prev_r;
      default: hit = 1'b0;                  // Disabled
    endcase
  end

  // Latch the counter on the edge
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_value_o <= CNT_ZERO;
    end else if (hit) begin
      cap_value_o <= cnt_i;
    end
  end

  // Flag: edge sets, writing 0 clears, set wins over clear
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_o <= 1'b0;
    end else if (hit) begin
      flag_o <= 1'b1;
    end else if (flag_wr_i && !flag_wdata_i) begin
      flag_o <= 1'b0;
    end
  end

  a_cap_latch: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    hit |=> (cap_value_o == $past(cnt_i)) && flag_o)
    else $error("capture did not latch counter");
  a_cap_keep: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (flag_wr_i && flag_wdata_i && !hit && flag_o) |=> flag_o)
    else $error("writing one altered capture flag");
  c_cap_edge: cover property (@(posedge core_clk_i) disable iff (!resetn_i) hit);
endmodule

// File: verilog/mtu_slice.sv
// Multi timer unit slice: counter, two compare channels with waveform gen,
// two capture channels, and converter start triggers.
// Assumes all controls are synchronous ports written by software logic.
`timescale 1ns/1ns

// Summary of operation
// - Counter and waveform timer count divided clock
// - Count up from zero to cycle value
// - Start and stop by software commands
// - Stopped counter loads software written value
// - Compare writes buffer, then transfer active
// - Each match inverts the compare output
// - Match sets flag and requests interrupt
// - Write one keeps flag, zero clears
// - Software sets compare output initial level
// - Output inverts on match only while channel enabled; disabled, it follows the initial level
// - Select counter per compare and capture pair
// - Compare high asserts pulse generator gate
// - While high, output combines pulse signal
// - Compare low deasserts the gate; the shared gate stays up while the other enabled compare is high
// - After fall, waveform output forced low
// - Capture edge selection set by software
// - Edge stores counter and requests interrupt
// - Six converter start outputs provided
// - Start outputs ORed with other units
// - Counter value exported to other units
// - Capture edge rising, falling or both
module mtu_slice (
  input wire logic core_clk_i,                                  // Core clock 25 MHz
  input wire logic resetn_i,                                    // Async reset, active low
  // Counter control
  input wire logic cnt_start_i,                                 // Start command pulse
  input wire logic cnt_stop_i,                                  // Stop command pulse
  input wire logic [mtu_pkg::DIV_W-1:0] cnt_div_i,              // Prescaler code
  input wire logic [mtu_pkg::CNT_W-1:0] cycle_value_i,          // Cycle value
  input wire logic cnt_load_i,                                  // Counter value write
  input wire logic [mtu_pkg::CNT_W-1:0] cnt_load_value_i,       // Counter load data
  input wire logic [mtu_pkg::CNT_W-1:0] ext_cnt0_i,             // Counter of other unit
  input wire logic [mtu_pkg::CNT_W-1:0] ext_cnt1_i,             // Counter of other unit
  output logic [mtu_pkg::CNT_W-1:0] counter_value_o,            // Own counter, exported
  output logic cnt_running_o,                                   // Counter is running
  // Compare control
  input wire logic [mtu_pkg::SEL_W-1:0] compare_counter_select_i, // Counter for pair
  input wire logic [mtu_pkg::NUM_CMP-1:0] cmp_enable_i,         // Channel enables
  input wire logic [mtu_pkg::NUM_CMP-1:0] cmp_buf_disable_i,    // Bypass buffer
  input wire logic [mtu_pkg::NUM_CMP-1:0] compare_output_level_i, // Initial levels
  input wire logic [mtu_pkg::NUM_CMP-1:0] cmp_int_enable_i,     // Interrupt enables
  input wire logic [mtu_pkg::NUM_CMP-1:0] cmp_wr_i,             // Compare value write
  input wire logic [mtu_pkg::CNT_W-1:0] compare_value_i,        // Compare write data
  input wire logic cmp_flag_wr_i,                               // Match flag write
  input wire logic [mtu_pkg::NUM_CMP-1:0] cmp_flag_wdata_i,     // Match flag data
  output logic [mtu_pkg::NUM_CMP-1:0] cmp_flag_o,               // Match flags
  output logic [mtu_pkg::NUM_CMP-1:0] cmp_irq_o,                // Match interrupt req
  output logic [mtu_pkg::NUM_CMP-1:0] compare_output_o,         // Compare outputs
  // Waveform generator
  input wire logic waveform_mode_control_i,                     // 1: pulse gated mode
  input wire logic [mtu_pkg::DIV_W-1:0] wf_div_i,               // Waveform timer prescale
  input wire logic pulse_gen_i,                                 // Pulse from generator
  output logic pulse_gen_gate_o,                                // Gate to generator
  output logic [mtu_pkg::NUM_CMP-1:0] waveform_output_o,        // Waveform outputs
  output logic wf_tick_o,                                       // Waveform timer enable
  // Capture
  input wire logic [mtu_pkg::SEL_W-1:0] capture_counter_select_i, // Counter for pair
  input wire logic [1:0] cap_edge0_i,                           // Ch0 edge selection
  input wire logic [1:0] cap_edge1_i,                           // Ch1 edge selection
  input wire logic [mtu_pkg::NUM_CAP-1:0] capture_input_i,      // Capture inputs
  input wire logic [mtu_pkg::NUM_CAP-1:0] cap_int_enable_i,     // Interrupt enables
  input wire logic cap_flag_wr_i,                               // Edge flag write
  input wire logic [mtu_pkg::NUM_CAP-1:0] cap_flag_wdata_i,     // Edge flag data
  output logic [mtu_pkg::CNT_W-1:0] capture_value0_o,           // Ch0 captured value
  output logic [mtu_pkg::CNT_W-1:0] capture_value1_o,           // Ch1 captured value
  output logic [mtu_pkg::NUM_CAP-1:0] cap_flag_o,               // Edge flags
  output logic [mtu_pkg::NUM_CAP-1:0] cap_irq_o,                // Capture interrupt req
  // Converter starts
  input wire logic [mtu_pkg::NUM_ADC-1:0] adc_scan_sel_i,       // Scan start on zero
  input wire logic [mtu_pkg::NUM_ADC-1:0] adc_prio_sel_i,       // Priority start on peak
  input wire logic [mtu_pkg::NUM_ADC-1:0] ext_scan_start_i,     // Scan starts of others
  input wire logic [mtu_pkg::NUM_ADC-1:0] ext_prio_start_i,     // Priority starts others
  output logic [mtu_pkg::NUM_ADC-1:0] adc_scan_start_o,         // Scan start triggers
  output logic [mtu_pkg::NUM_ADC-1:0] adc_prio_start_o          // Priority triggers
);
  import mtu_pkg::*;

  // Pick one of the three counters from a select code
  function automatic logic [CNT_W-1:0] pick_cnt(input logic [SEL_W-1:0] sel,
      input logic [CNT_W-1:0] own, input logic [CNT_W-1:0] e0,
      input logic [CNT_W-1:0] e1);
    case (sel)
      2'h1: pick_cnt = e0;
      2'h2: pick_cnt = e1;
      default: pick_cnt = own;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Free run counter
  logic run_r;            // Counting
  logic cnt_tick;         // Count enable
  logic [CNT_W-1:0] cnt_r; // Counter
  logic zero_evt_r;       // Counter wrapped to zero
  logic peak_evt_r;       // Counter reached cycle value

  // Start and stop commands; stop wins if both arrive together
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_r <= 1'b0;
    end else if (cnt_stop_i) begin
      run_r <= 1'b0;
    end else if (cnt_start_i) begin
      run_r <= 1'b1;
    end
  end

  mtu_prescale u_cnt_div (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .run_i(run_r),
    .code_i(cnt_div_i),
    .tick_o(cnt_tick)
  );

  // Counting; the load only takes effect while stopped
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= CNT_ZERO;
      zero_evt_r <= 1'b0;
      peak_evt_r <= 1'b0;
    end else begin
      zero_evt_r <= 1'b0;
      peak_evt_r <= 1'b0;
      if (!run_r && cnt_load_i) begin
        cnt_r <= cnt_load_value_i;
      end else if (cnt_tick) begin
        if (cnt_r == cycle_value_i) begin
          cnt_r <= CNT_ZERO;
          zero_evt_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
          peak_evt_r <= (cnt_r + 16'h0001) == cycle_value_i;
        end
      end
    end
  end

  assign counter_value_o = cnt_r;
  assign cnt_running_o = run_r;

  a_cnt_wrap: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (cnt_tick && !cnt_load_i && cnt_r == cycle_value_i) |=> cnt_r == CNT_ZERO)
    else $error("counter did not wrap at cycle value");
  a_cnt_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (!run_r && !cnt_load_i) |=> $stable(cnt_r))
    else $error("stopped counter moved");
  a_cnt_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (!run_r && cnt_load_i) |=> cnt_r == $past(cnt_load_value_i))
    else $error("stopped counter did not load");
  c_cnt_wrap: cover property (@(posedge core_clk_i) disable iff (!resetn_i) zero_evt_r);

  ////////////////////////////////////////////////////////////////////////
  // Compare channels
  logic [CNT_W-1:0] cmp_cnt;                // Counter feeding the pair
  logic [CNT_W-1:0] cmp_buf_r [NUM_CMP];    // Buffer registers
  logic [CNT_W-1:0] cmp_act_r [NUM_CMP];    // Active compare values
  logic [NUM_CMP-1:0] cmp_pend_r;           // Buffer holds untransferred value
  logic [NUM_CMP-1:0] match;                // Match this cycle
  logic [CNT_W-1:0] cmp_cnt_q;              // Counter seen last cycle

  assign cmp_cnt = pick_cnt(compare_counter_select_i, cnt_r, ext_cnt0_i, ext_cnt1_i);

  // A match fires once per counter value, not every core cycle it is held
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_cnt_q <= CNT_ZERO;
    end else begin
      cmp_cnt_q <= cmp_cnt;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      match[i] = cmp_enable_i[i] && (cmp_cnt == cmp_act_r[i]) && (cmp_cnt != cmp_cnt_q);
    end
  end

  // Buffer then transfer at counter zero, or straight through when bypassed
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        cmp_buf_r[i] <= CNT_ZERO;
        cmp_act_r[i] <= CNT_ZERO;
      end
      cmp_pend_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (cmp_wr_i[i]) begin
          cmp_buf_r[i] <= compare_value_i;
          cmp_pend_r[i] <= 1'b1;
        end else if (cmp_pend_r[i] && (cmp_buf_disable_i[i] || !cmp_enable_i[i] ||
                     cmp_cnt == CNT_ZERO)) begin
          cmp_act_r[i] <= cmp_buf_r[i];
          cmp_pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // Output toggles on match while enabled; initial level while disabled
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_output_o <= '0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (!cmp_enable_i[i]) begin
          compare_output_o[i] <= compare_output_level_i[i];
        end else if (match[i]) begin
          compare_output_o[i] <= !compare_output_o[i];
        end
      end
    end
  end

  // Match flag: match sets, write 0 clears, set wins
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_flag_o <= '0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (match[i]) begin
          cmp_flag_o[i] <= 1'b1;
        end else if (cmp_flag_wr_i && !cmp_flag_wdata_i[i]) begin
          cmp_flag_o[i] <= 1'b0;
        end
      end
    end
  end

  assign cmp_irq_o = cmp_flag_o & cmp_int_enable_i;

  a_cmp_toggle: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (match[0] && cmp_enable_i[0]) |=> compare_output_o[0] != $past(compare_output_o[0]))
    else $error("compare output did not invert on match");
  a_cmp_flag: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    match[0] |=> cmp_flag_o[0] && (cmp_irq_o[0] == cmp_int_enable_i[0]))
    else $error("match flag not raised");
  a_cmp_keep: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (cmp_flag_o[0] && cmp_flag_wr_i && cmp_flag_wdata_i[0]) |=> cmp_flag_o[0])
    else $error("writing one cleared match flag");
  a_cmp_idle: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (!cmp_enable_i[1] ##1 !cmp_enable_i[1])
      |-> compare_output_o[1] == $past(compare_output_level_i[1]))
    else $error("disabled output not at initial level");
  c_cmp_match: cover property (@(posedge core_clk_i) disable iff (!resetn_i) match[0]);

  ////////////////////////////////////////////////////////////////////////
  // Waveform generator; timer enable kept for dead time style modes
  logic wf_gate; // Either compare output high

  mtu_prescale u_wf_div (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .run_i(waveform_mode_control_i),
    .code_i(wf_div_i),
    .tick_o(wf_tick_o)
  );

  // Gate is the OR of both enabled compare outputs, as the pair shares one generator
  assign wf_gate = waveform_mode_control_i && (|(compare_output_o & cmp_enable_i));

  // Registered gate and superimposed outputs; a disabled channel stays low in pulse gated mode
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_gen_gate_o <= 1'b0;
      waveform_output_o <= '0;
    end else begin
      pulse_gen_gate_o <= wf_gate;
      for (int i = 0; i < NUM_CMP; i++) begin
        if (!waveform_mode_control_i) begin
          waveform_output_o[i] <= compare_output_o[i];
        end else if (cmp_enable_i[i] && compare_output_o[i]) begin
          waveform_output_o[i] <= pulse_gen_i;
        end else begin
          waveform_output_o[i] <= 1'b0;
        end
      end
    end
  end

  a_wf_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (waveform_mode_control_i && cmp_enable_i[0] && $rose(compare_output_o[0]))
      |=> pulse_gen_gate_o)
    else $error("gate not asserted on compare rise");
  a_wf_low: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (waveform_mode_control_i && !compare_output_o[0]) |=> !waveform_output_o[0])
    else $error("waveform output not low after fall");
  a_wf_super: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (waveform_mode_control_i && cmp_enable_i[0] && compare_output_o[0])
      |=> waveform_output_o[0] == $past(pulse_gen_i))
    else $error("pulse not superimposed");
  c_wf_gate: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    $fell(pulse_gen_gate_o));

  ////////////////////////////////////////////////////////////////////////
  // Capture channels on the selected counter
  logic [CNT_W-1:0] cap_cnt; // Counter feeding the pair

  assign cap_cnt = pick_cnt(capture_counter_select_i, cnt_r, ext_cnt0_i, ext_cnt1_i);

  mtu_capture u_cap0 (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .edge_sel_i(cap_edge0_i),
    .cap_in_i(capture_input_i[0]),
    .cnt_i(cap_cnt),
    .flag_wr_i(cap_flag_wr_i),
    .flag_wdata_i(cap_flag_wdata_i[0]),
    .cap_value_o(capture_value0_o),
    .flag_o(cap_flag_o[0])
  );

  mtu_capture u_cap1 (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .edge_sel_i(cap_edge1_i),
    .cap_in_i(capture_input_i[1]),
    .cnt_i(cap_cnt),
    .flag_wr_i(cap_flag_wr_i),
    .flag_wdata_i(cap_flag_wdata_i[1]),
    .cap_value_o(capture_value1_o),
    .flag_o(cap_flag_o[1])
  );

  assign cap_irq_o = cap_flag_o & cap_int_enable_i;

  ////////////////////////////////////////////////////////////////////////
  // Converter starts: own zero or peak events ORed with other units
  always_comb begin
    for (int i = 0; i < NUM_ADC; i++) begin
      adc_scan_start_o[i] = (adc_scan_sel_i[i] & zero_evt_r) | ext_scan_start_i[i];
      adc_prio_start_o[i] = (adc_prio_sel_i[i] & peak_evt_r) | ext_prio_start_i[i];
    end
  end

  a_adc_or: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ext_scan_start_i[0] |-> adc_scan_start_o[0])
    else $error("external scan start lost");
endmodule

// File: sim/mtu_pgen_model.sv
// Pulse generator stand-in driving the slice's pulse input.
// Assumes its gate comes from the slice on the same core clock.
`timescale 1ns/1ns
module mtu_pgen_model (
  input wire logic core_clk_i, // Core clock
  input wire logic gate_i,     // Start gate
  output logic pulse_o         // Pulse train
);
  initial pulse_o = 1'b0;
  // Toggles while gated, parks low once released
  always @(posedge core_clk_i) pulse_o <= gate_i ? ~pulse_o : 1'b0;
endmodule

// File: sim/tb.sv
// Self-checking bench for the timer slice with a reference counter model.
// Assumes divide code 0, so the counter moves on every running cycle.
`timescale 1ns/1ns
module tb;
  import mtu_pkg::*;
  logic core_clk_i = 1'b0, resetn_i = 1'b0, cnt_start_i = 0, cnt_stop_i = 0, cnt_load_i = 0;
  logic cmp_flag_wr_i = 0, cap_flag_wr_i = 0, waveform_mode_control_i = 1, pulse_gen_i;
  logic pulse_gen_gate_o, wf_tick_o, cnt_running_o, cs, ps;
  logic [DIV_W-1:0] cnt_div_i = '0, wf_div_i = '0;
  logic [CNT_W-1:0] cycle_value_i = 16'h0009, cnt_load_value_i = '0, compare_value_i = '0;
  logic [CNT_W-1:0] ext_cnt0_i = '0, ext_cnt1_i = '0, counter_value_o, ld, cv, cap_exp = '0;
  logic [CNT_W-1:0] capture_value0_o, capture_value1_o;
  logic [SEL_W-1:0] compare_counter_select_i = '0, capture_counter_select_i = '0;
  logic [NUM_CMP-1:0] cmp_enable_i = '0, cmp_buf_disable_i = 2'h3, compare_output_level_i = '0;
  logic [NUM_CMP-1:0] cmp_int_enable_i = 2'h3, cmp_wr_i = '0, cmp_flag_wdata_i = '0;
  logic [NUM_CMP-1:0] cmp_flag_o, cmp_irq_o, compare_output_o, waveform_output_o;
  logic [1:0] cap_edge0_i = '0, cap_edge1_i = '0;
  logic [NUM_CAP-1:0] capture_input_i = '0, cap_int_enable_i = 2'h3, cap_flag_wdata_i = '0;
  logic [NUM_CAP-1:0] cap_flag_o, cap_irq_o;
  logic [NUM_ADC-1:0] adc_scan_sel_i = 3'h1, adc_prio_sel_i = 3'h1, ext_scan_start_i = '0;
  logic [NUM_ADC-1:0] ext_prio_start_i = '0, adc_scan_start_o, adc_prio_start_o;
  int failures = 0, tests_run = 0, seed = 56539, m_cnt = 0, n;
  bit m_run = 0, m_zero = 0, m_peak = 0;
  mtu_slice dut (.*);
  mtu_pgen_model pgen (.core_clk_i(core_clk_i), .gate_i(pulse_gen_gate_o), .pulse_o(pulse_gen_i));
  always #20 core_clk_i = ~core_clk_i;
  //////////////////////////////////////////////////////////////////////////
  // Reference counter: loads only while stopped, wraps after the cycle value
  always @(posedge core_clk_i) begin
    if (m_run) m_cnt <= (m_cnt == cycle_value_i) ? 0 : m_cnt + 1;
    else if (cnt_load_i) m_cnt <= cnt_load_value_i;
    m_run <= cnt_stop_i ? 1'b0 : (cnt_start_i ? 1'b1 : m_run);
    // Zero event on the wrap, peak event when the cycle value is reached
    m_zero <= m_run && m_cnt == cycle_value_i;
    m_peak <= m_run && m_cnt != cycle_value_i && m_cnt + 1 == cycle_value_i;
    cs <= compare_output_o[0];
    ps <= pulse_gen_i;
  end
  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Settled values are compared mid-cycle, clear of the launching edge
  always @(negedge core_clk_i) if (resetn_i) begin
    chk(counter_value_o, m_cnt[CNT_W-1:0]);
    chk(pulse_gen_gate_o, cs);
    chk(waveform_output_o[0], cs & ps);
    chk({cnt_running_o, wf_tick_o}, {m_run, waveform_mode_control_i});
    chk(adc_scan_start_o[0], m_zero | ext_scan_start_i[0]);
    chk(adc_prio_start_o[0], m_peak | ext_prio_start_i[0]);
  end
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask
  task automatic wait_flag;
    n = 0;
    while (cmp_flag_o[0] !== 1'b1 && n < 60) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask
  task automatic close_out;
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    close_out();
  end
  //////////////////////////////////////////////////////////////////////////
  // Main sequence: counter, compare, capture, converter starts
  initial begin
    tick(3);
    chk({cnt_running_o, compare_output_o, cap_flag_o, cmp_flag_o}, '0);
    resetn_i <= 1'b1;
    ld = $random(seed);
    cnt_load_value_i <= ld;
    cnt_load_i <= 1'b1;
    tick(1);
    cnt_load_value_i <= '0;
    tick(1);
    cnt_load_i <= 1'b0;
    cnt_start_i <= 1'b1;
    tick(1);
    cnt_start_i <= 1'b0;
    tick(40);
    chk(compare_output_o[0], 1'b0);
    // Value lands while disabled, so no stale active value can match first
    cv = 16'h0001 + ($random(seed) & 7);
    compare_value_i <= cv;
    cmp_wr_i <= 2'h1;
    tick(1);
    cmp_wr_i <= '0;
    tick(1);
    cmp_enable_i <= 2'h1;
    wait_flag();
    chk({compare_output_o[0], cmp_irq_o[0]}, 2'h3);
    chk(counter_value_o, cv + 16'h0001);
    tick(1);
    cnt_stop_i <= 1'b1;
    cmp_flag_wr_i <= 1'b1;
    cmp_flag_wdata_i <= 2'h3;
    tick(1);
    cnt_stop_i <= 1'b0;
    cmp_flag_wdata_i <= 2'h0;
    @(negedge core_clk_i);
    chk(cmp_flag_o[0], 1'b1);
    tick(1);
    cmp_flag_wr_i <= 1'b0;
    tick(1);
    chk({compare_output_o[0], cmp_flag_o[0]}, 2'h2);
    cnt_start_i <= 1'b1;
    tick(1);
    cnt_start_i <= 1'b0;
    wait_flag();
    chk(compare_output_o[0], 1'b0);
    chk(counter_value_o, cv + 16'h0001);
    tick(1);
    cnt_stop_i <= 1'b1;
    cmp_enable_i <= '0;
    tick(3);
    cnt_stop_i <= 1'b0;
    // Disabled channels show their initial level, the generator stays idle
    compare_output_level_i <= 2'h2;
    tick(2);
    chk({compare_output_o, waveform_output_o, pulse_gen_gate_o}, 5'h10);
    // A fresh counter value each pass shows whether the edge captured or not
    for (int c = 1; c < 4; c++) begin
      for (int r = 1; r >= 0; r--) begin
        ld = $random(seed);
        cnt_load_value_i <= ld;
        cnt_load_i <= 1'b1;
        tick(1);
        cnt_load_i <= 1'b0;
        cap_edge0_i <= c[1:0];
        capture_input_i <= {1'b0, r[0]};
        tick(3);
        if (r ? c[0] : c[1]) cap_exp = ld;
        chk({cap_flag_o[0], cap_irq_o[0]}, r ? {2{c[0]}} : {2{c[1]}});
        chk(capture_value0_o, cap_exp);
        cap_flag_wr_i <= 1'b1;
        tick(1);
        cap_flag_wr_i <= 1'b0;
      end
    end
    // Second channel captures the counter of another unit
    ext_cnt0_i <= $random(seed);
    capture_counter_select_i <= 2'h1;
    cap_edge1_i <= EDGE_RISE;
    capture_input_i <= 2'h2;
    tick(3);
    chk(capture_value1_o, ext_cnt0_i);
    chk({cap_flag_o, cap_irq_o}, 4'hA);
    // Pass-through mode shows the compare outputs one cycle later
    waveform_mode_control_i <= 1'b0;
    tick(2);
    chk(waveform_output_o, 2'h2);
    ext_scan_start_i <= 3'h5;
    ext_prio_start_i <= 3'h2;
    tick(2);
    chk({adc_scan_start_o, adc_prio_start_o}, 6'h2A);
    close_out();
  end
endmodule
